// [hdl/sbc_regs.svh]
// Register map, field positions and counts for the sample buffer control
// Notes on behaviour
// - Writing 1 to the purge bit empties the buffer and clears every buffer event flag.
// - A purge also clears the gate error flag and the five-bit gate sample counter.
// - The purge bit clears itself in one cycle, so a register read always returns 0 there.
// - The sleep-hold bit at 0 ignores the watermark-or-overflow condition; at 1 its rise forces WAKE and restarts the timer.
// - With sleep-hold on, SLEEP is entered when the auto-sleep timer expires with flags uncleared.
// - Clearing the flags by purge, or by reading samples while in WAKE, restarts the timer and leaves it in WAKE.
// - Sleep-hold only acts in stream or stop buffer mode.
// - The watermark flag is high whenever the sample count is at or above a nonzero threshold.
// - A threshold of zero never raises the watermark flag.
// - In triggered mode the threshold caps the number of pre-trigger samples kept.
// - Selecting the disabled buffer mode flushes the buffer like a purge.
// - Triggered: fill 32 minus threshold, ignore retriggers, set overflow, stop until emptied.
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH
`define SBC_CFG2_ADDR 8'h27
`define SBC_CFG2_RESET 8'h00
`define SBC_PURGE_BIT 7
`define SBC_HOLD_BIT 6
`define SBC_LVL_MSB 5
`define SBC_LVL_LSB 0
`define SBC_DEPTH 6'h20
`define SBC_GATE_W 5
`endif

// [hdl/sbc_pkg.sv]
// Types for the sample buffer control
package sbc_pkg;
    typedef enum logic [1:0] {
        SBC_OFF = 2'h0,
        SBC_STREAM = 2'h1,
        SBC_STOP = 2'h2,
        SBC_TRIG = 2'h3
    } sbc_mode_t;
    typedef enum logic [1:0] {
        SBC_WAKE = 2'h1,
        SBC_SLEEP = 2'h2
    } sbc_pwr_t;
endpackage

// [hdl/sbc_top.sv]
// Buffer configuration register, sample count, flags and auto-sleep hold
`timescale 1ns/1ps
`include "sbc_regs.svh"
module sbc_top
    import sbc_pkg::*;
#(
    parameter int DW = 36,
    parameter int PW = 8
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Buffer mode and host sample reads
    input wire logic [1:0] BUF_MODE,
    input wire logic SAMPLE_READ,
    input wire logic TRIG,
    // Auto-sleep timing
    input wire logic [PW-1:0] AUTO_SLEEP_PERIOD,
    input wire logic ODR_TICK,
    // Incoming samples
    input wire logic SMP_VALID,
    input wire logic [DW-1:0] SMP_DATA,
    output logic SMP_READY,
    // Samples toward storage
    output logic OUT_VALID,
    output logic [DW-1:0] OUT_DATA,
    input wire logic OUT_READY,
    // Status
    output logic [5:0] SAMPLE_COUNT,
    output logic WMRK_FLAG,
    output logic BUFFER_OVERFLOW_FLAG,
    output logic STORE_FLUSH,
    output logic DROP_OLDEST,
    output logic GATE_CLEAR,
    output logic SLEEP_MODE
);
    // Configuration register
    logic hold_q, hold_d;
    logic [5:0] lvl_q, lvl_d;
    logic [7:0] rdata_q, rdata_d;
    logic cfg_hit;
    logic purge_wr;

    always_comb begin
        cfg_hit = REG_ADDR == `SBC_CFG2_ADDR;
        purge_wr = REG_WR && cfg_hit && REG_WDATA[`SBC_PURGE_BIT];
        hold_d = hold_q;
        lvl_d = lvl_q;
        rdata_d = rdata_q;
        if (REG_WR && cfg_hit) begin
            hold_d = REG_WDATA[`SBC_HOLD_BIT];
            lvl_d = REG_WDATA[`SBC_LVL_MSB:`SBC_LVL_LSB];
        end
        if (REG_RD) begin
            rdata_d = 8'h00;
            if (cfg_hit) begin
                rdata_d = {1'b0, hold_q, lvl_q};
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            hold_q <= 1'b0;
            lvl_q <= 6'h00;
            rdata_q <= 8'h00;
        end else begin
            hold_q <= hold_d;
            lvl_q <= lvl_d;
            rdata_q <= rdata_d;
        end
    end

    // Flush on a purge write and while the mode is disabled, purge bit never stored
    logic flush_q, flush_d;
    always_comb begin
        flush_d = purge_wr || (BUF_MODE == SBC_OFF);
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= flush_d;
        end
    end

    // Two-entry buffer
    logic [DW-1:0] ent_q [2];
    logic [DW-1:0] ent_d [2];
    logic [1:0] fill_q, fill_d;
    logic rdy_q, rdy_d;
    logic ov_q, ov_d;
    logic push, pop;
    logic stop_q, stop_d;

    always_comb begin
        push = SMP_VALID && rdy_q;
        pop = ov_q && OUT_READY;
        ent_d = ent_q;
        fill_d = fill_q;
        if (pop) begin
            ent_d[0] = ent_q[1];
            fill_d = fill_q - 2'h1;
        end
        if (push) begin
            ent_d[fill_d[0]] = SMP_DATA;
            fill_d = fill_d + 2'h1;
        end
        if (flush_q) begin
            fill_d = 2'h0;
        end
        rdy_d = fill_d != 2'h2;
        ov_d = (fill_d != 2'h0) && !stop_d;
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ent_q[0] <= '0;
            ent_q[1] <= '0;
            fill_q <= 2'h0;
            rdy_q <= 1'b0;
            ov_q <= 1'b0;
        end else begin
            ent_q <= ent_d;
            fill_q <= fill_d;
            rdy_q <= rdy_d;
            ov_q <= ov_d;
        end
    end

    // Sample count, flags and triggered capture
    logic [5:0] cnt_q, cnt_d;
    logic wm_q, wm_d;
    logic ovf_q, ovf_d;
    logic armed_q, armed_d;
    logic drop_q, drop_d;
    logic gclr_q, gclr_d;
    logic rd_ok;
    logic full;

    always_comb begin
        cnt_d = cnt_q;
        ovf_d = ovf_q;
        stop_d = stop_q;
        armed_d = armed_q;
        drop_d = 1'b0;
        rd_ok = SAMPLE_READ && (cnt_q != 6'h00);
        full = cnt_q == `SBC_DEPTH;
        if (rd_ok) begin
            cnt_d = cnt_q - 6'h01;
            ovf_d = 1'b0;
        end
        if (BUF_MODE == SBC_TRIG && !armed_q && TRIG) begin
            armed_d = 1'b1;
        end
        if (pop) begin
            unique case (BUF_MODE)
                SBC_TRIG: begin
                    // Past the cap the oldest is pushed out
                    if (!armed_q && cnt_q >= lvl_q) begin
                        drop_d = 1'b1;
                    end else begin
                        cnt_d = cnt_d + 6'h01;
                    end
                end
                SBC_STREAM: begin
                    if (full && !rd_ok) begin
                        drop_d = 1'b1;
                    end else begin
                        cnt_d = cnt_d + 6'h01;
                    end
                end
                default: begin
                    cnt_d = cnt_d + 6'h01;
                end
            endcase
        end
        // Set wins over a same-cycle read
        if (cnt_d == `SBC_DEPTH && BUF_MODE != SBC_OFF) begin
            ovf_d = 1'b1;
            stop_d = BUF_MODE != SBC_STREAM;
        end
        // Emptying a stopped capture rearms it
        if (cnt_d == 6'h00) begin
            stop_d = 1'b0;
            if (stop_q) begin
                armed_d = 1'b0;
            end
        end
        if (BUF_MODE != SBC_TRIG) begin
            armed_d = 1'b0;
        end
        if (flush_q) begin
            cnt_d = 6'h00;
            ovf_d = 1'b0;
            stop_d = 1'b0;
            armed_d = 1'b0;
            drop_d = 1'b0;
        end
        wm_d = (lvl_q != 6'h00) && (cnt_d >= lvl_q);
        gclr_d = flush_q || (rd_ok && cnt_d == 6'h00);
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cnt_q <= 6'h00;
            wm_q <= 1'b0;
            ovf_q <= 1'b0;
            stop_q <= 1'b0;
            armed_q <= 1'b0;
            drop_q <= 1'b0;
            gclr_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            wm_q <= wm_d;
            ovf_q <= ovf_d;
            stop_q <= stop_d;
            armed_q <= armed_d;
            drop_q <= drop_d;
            gclr_q <= gclr_d;
        end
    end

    // Auto-sleep timer and power state
    sbc_pwr_t pwr_q, pwr_d;
    logic [PW-1:0] tmr_q, tmr_d;
    logic flg_q, flg_d;
    logic hold_act;
    logic flg_clr;
    logic flg_set;
    logic sleep_q, sleep_d;

    always_comb begin
        // Hold only in stream and stop modes
        hold_act = hold_q && (BUF_MODE == SBC_STREAM || BUF_MODE == SBC_STOP);
        flg_d = wm_q || ovf_q;
        flg_set = hold_act && flg_d && !flg_q;
        flg_clr = hold_act && flg_q && !flg_d && pwr_q == SBC_WAKE;
        pwr_d = pwr_q;
        tmr_d = tmr_q;
        if (flush_q || flg_clr || flg_set || (BUF_MODE == SBC_TRIG && armed_q)) begin
            tmr_d = '0;
            pwr_d = SBC_WAKE;
        end else begin
            // Timer runs only while awake
            unique case (pwr_q)
                SBC_WAKE: begin
                    if (ODR_TICK && AUTO_SLEEP_PERIOD != '0) begin
                        if (tmr_q + PW'(1) >= AUTO_SLEEP_PERIOD) begin
                            pwr_d = SBC_SLEEP;
                            tmr_d = '0;
                        end else begin
                            tmr_d = tmr_q + PW'(1);
                        end
                    end
                end
                SBC_SLEEP: begin
                    tmr_d = '0;
                end
            endcase
        end
        sleep_d = pwr_d == SBC_SLEEP;
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pwr_q <= SBC_WAKE;
            tmr_q <= '0;
            flg_q <= 1'b0;
            sleep_q <= 1'b0;
        end else begin
            pwr_q <= pwr_d;
            tmr_q <= tmr_d;
            flg_q <= flg_d;
            sleep_q <= sleep_d;
        end
    end

    // Outputs
    always_comb begin
        // Register and stream side
        REG_RDATA = rdata_q;
        SMP_READY = rdy_q;
        OUT_VALID = ov_q;
        OUT_DATA = ent_q[0];
        // Status side
        SAMPLE_COUNT = cnt_q;
        WMRK_FLAG = wm_q;
        BUFFER_OVERFLOW_FLAG = ovf_q;
        STORE_FLUSH = flush_q;
        DROP_OLDEST = drop_q;
        GATE_CLEAR = gclr_q;
        SLEEP_MODE = sleep_q;
    end
endmodule

// [tb/sbc_monitor.sv]
// Port assertions for the sample buffer control
`timescale 1ns/1ps
module sbc_monitor (
    // Watched ports
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic [1:0] BUF_MODE,
    input wire logic [5:0] SAMPLE_COUNT,
    input wire logic WMRK_FLAG,
    input wire logic BUFFER_OVERFLOW_FLAG,
    input wire logic STORE_FLUSH,
    input wire logic GATE_CLEAR,
    input wire logic SLEEP_MODE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    logic [6:0] cfg_q;
    wire wr27 = REG_WR && REG_ADDR == 8'h27;
    // Shadow of hold bit and threshold
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) cfg_q <= 7'h00;
        else if (wr27) cfg_q <= REG_WDATA[6:0];
    end
    sequence purge_s;
        wr27 && REG_WDATA[7];
    endsequence
    sequence empty_s;
        SAMPLE_COUNT == 6'h00 && !WMRK_FLAG && !BUFFER_OVERFLOW_FLAG;
    endsequence
    flush_clear_a: assert property (purge_s |=> STORE_FLUSH ##1 empty_s)
        else $error("purge left data");
    gate_clear_a: assert property (purge_s |-> ##2 GATE_CLEAR)
        else $error("no gate clear");
    purge_reads_a: assert property (REG_RD |=> !REG_RDATA[7])
        else $error("purge bit read high");
    wmrk_level_a: assert property ($stable(cfg_q) |->
        WMRK_FLAG == (cfg_q[5:0] != 6'h00 && SAMPLE_COUNT >= cfg_q[5:0]))
        else $error("watermark wrong");
    wmrk_zero_a: assert property (cfg_q[5:0] == 6'h00 [*2] |-> !WMRK_FLAG)
        else $error("watermark at zero");
    hold_off_a: assert property (!cfg_q[6] && BUF_MODE inside {2'h1, 2'h2} && SLEEP_MODE
        && !STORE_FLUSH && !REG_WR |=> SLEEP_MODE)
        else $error("woke without hold");
    flush_wake_a: assert property (STORE_FLUSH |-> ##[0:1] !SLEEP_MODE)
        else $error("flush kept sleep");
    off_flush_a: assert property (BUF_MODE == 2'h0 [*2] |=> STORE_FLUSH and empty_s)
        else $error("off mode kept data");
    trig_full_a: assert property (BUF_MODE == 2'h3 && $rose(BUFFER_OVERFLOW_FLAG)
        |-> SAMPLE_COUNT == 6'h20)
        else $error("capture overflow early");
endmodule
bind sbc_top sbc_monitor i_sbc_monitor (.CLK, .NRST, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD,
    .REG_RDATA, .BUF_MODE, .SAMPLE_COUNT, .WMRK_FLAG, .BUFFER_OVERFLOW_FLAG, .STORE_FLUSH,
    .GATE_CLEAR, .SLEEP_MODE);

// [tb/sbc_sink.sv]
// Storage side model that accepts words with optional stalls
`timescale 1ns/1ps
module sbc_sink (
    // Clock and stall control
    input wire logic clk,
    input wire logic stall,
    // Ready toward the block
    output logic out_ready
);
    logic [1:0] ph_q = 2'h0;
    logic rdy_q = 1'b0;
    always @(negedge clk) begin
        ph_q <= ph_q + 2'h1;
        rdy_q <= !(stall && ph_q != 2'h0);
    end
    assign out_ready = rdy_q;
endmodule

// [tb/sample_buffer_config_control_bench.sv]
// Self-checking bench for the sample buffer control
`timescale 1ns/1ps
module sample_buffer_config_control_bench;
    logic clk = 0, nrst = 0, wr = 0, rd = 0, s_read = 0, trig = 0, tick = 0, s_valid = 0;
    logic stall = 1;
    logic [7:0] addr = 8'h27, wdata = 8'h00, period = 8'h00;
    logic [1:0] mode = 2'h1;
    logic [35:0] s_data = 36'h0;
    wire [7:0] rdata;
    wire [5:0] count;
    wire s_ready, o_valid, o_ready, wmrk, ovf, flush, gclr, sleep, drop;
    wire [35:0] o_data;
    int n_fail = 0, n_checks = 0;
    int n_sent = 0, n_drop = 0;
    logic [7:0] n_out = 8'h00;
    logic ov_s = 0;
    logic [35:0] od_s = 36'h0;
    always #2 clk = ~clk;
    sbc_top i_sbc_top (.CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
        .REG_RD(rd), .REG_RDATA(rdata), .BUF_MODE(mode), .SAMPLE_READ(s_read), .TRIG(trig),
        .AUTO_SLEEP_PERIOD(period), .ODR_TICK(tick), .SMP_VALID(s_valid), .SMP_DATA(s_data),
        .SMP_READY(s_ready), .OUT_VALID(o_valid), .OUT_DATA(o_data), .OUT_READY(o_ready),
        .SAMPLE_COUNT(count), .WMRK_FLAG(wmrk), .BUFFER_OVERFLOW_FLAG(ovf), .STORE_FLUSH(flush),
        .DROP_OLDEST(drop), .GATE_CLEAR(gclr), .SLEEP_MODE(sleep));
    sbc_sink i_sbc_sink (.clk(clk), .stall(stall), .out_ready(o_ready));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    always @(negedge clk) begin
        if (drop) n_drop++;
        if (ov_s && o_ready) begin
            chk(od_s[7:0], n_out);
            n_out++;
        end
        ov_s = o_valid;
        od_s = o_data;
    end
    task automatic conclude();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wreg(input logic [7:0] d);
        @(negedge clk) {wr, wdata} = {1'b1, d};
        @(negedge clk) wr = 0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk) {rd, addr} = {1'b1, a};
        @(negedge clk) {rd, addr} = {1'b0, 8'h27};
        @(negedge clk) chk(rdata, exp);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk) s = 1;
        @(negedge clk) s = 0;
    endtask
    task automatic push(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            @(negedge clk) {s_valid, s_data} = {1'b1, 36'(n_sent)};
            n_sent++;
            k = 0;
            while (s_ready !== 1'b1 && k < 50) begin
                @(negedge clk);
                k++;
            end
            if (s_ready !== 1'b1) begin
                n_fail++;
                conclude();
            end
        end
        @(negedge clk) s_valid = 0;
        repeat (20) @(negedge clk);
    endtask
    task automatic t_regs();
        rreg(8'h27, 8'h00);
        rreg(8'h28, 8'h00);
        wreg(8'hC5);
        rreg(8'h27, 8'h45);
    endtask
    task automatic t_wmrk();
        wreg(8'h83);
        push(2);
        chk(wmrk, 0);
        push(1);
        chk(count, 3);
        chk(wmrk, 1);
        wreg(8'h03);
        wreg(8'h00);
        @(negedge clk) chk(wmrk, 0);
    endtask
    task automatic t_purge();
        wreg(8'h80);
        chk(flush, 1);
        @(negedge clk) chk(gclr, 1);
        chk(count, 0);
    endtask
    task automatic t_full();
        push(33);
        chk(count, 8'h20);
        chk(ovf, 1);
        pulse(s_read);
        @(negedge clk) chk(ovf, 0);
        chk(count, 8'h1F);
        mode = 0;
        repeat (3) @(negedge clk);
        chk(count, 0);
        mode = 1;
    endtask
    task automatic t_sleep();
        period = 8'h03;
        wreg(8'h80);
        repeat (4) pulse(tick);
        @(negedge clk) chk(sleep, 1);
        wreg(8'hC2);
        repeat (2) @(negedge clk);
        chk(sleep, 0);
        mode = 2;
        push(2);
        repeat (2) pulse(tick);
        pulse(s_read);
        repeat (2) pulse(tick);
        chk(sleep, 0);
        push(1);
        repeat (4) pulse(tick);
        @(negedge clk) chk(sleep, 1);
        period = 8'h00;
    endtask
    task automatic t_trig();
        int d0;
        mode = 3;
        wreg(8'h84);
        d0 = n_drop;
        push(6);
        chk(count, 4);
        chk(8'(n_drop - d0), 8'h02);
        pulse(trig);
        push(28);
        chk(count, 8'h20);
        chk(ovf, 1);
    endtask
    initial begin
        repeat (20) @(negedge clk);
        nrst = 1;
        @(negedge clk);
        t_regs();
        t_wmrk();
        t_purge();
        t_full();
        t_sleep();
        t_trig();
        chk(n_out, 8'(n_sent));
        conclude();
    end
endmodule
